// file: rts_consts.svh
// constants for the two-wire register link
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH

// seven-bit slave addresses by strap level
`define RTS_ADDR_SEL_HI   7'h32
`define RTS_ADDR_SEL_LO   7'h51

// direction bit after the address
`define RTS_DIR_WRITE     1'b0
`define RTS_DIR_READ      1'b1

// register store and pointer
`define RTS_NUM_REGS      16
`define RTS_PTR_RST       4'h0
`define RTS_REG_RST       8'h00

// bit index of the acknowledge slot within a byte
`define RTS_ACK_BIT       4'h8

// bus timeout, in seconds, and the link clock period in ns
`define RTS_TMO_S         1
`define RTS_LNK_PERIOD_NS 80
`define RTS_TMO_CYCLES    ((`RTS_TMO_S * 1000000000 + `RTS_LNK_PERIOD_NS - 1) / `RTS_LNK_PERIOD_NS)

// host clock cycles per quarter of a serial clock period
`define RTS_QTR_CYCLES    5

// write feed word: pointer and data, and buffer depth
`define RTS_WORD_W        12
`define RTS_BUF_DEPTH     2

`endif

// file: rts_pkg.sv
// types shared by both ends of the two-wire link
package rts_pkg;

    // slave link engine states
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK, ST_IGNORE
    } rts_sst_type;

    // host sequencer states
    typedef enum logic [1:0] {M_IDLE, M_RUN} rts_mst_type;

    // host command kinds
    typedef enum logic [1:0] {
        RTS_CMD_START, RTS_CMD_WRITE, RTS_CMD_READ, RTS_CMD_STOP
    } rts_cmd_type;

endpackage

// file: rts_if.sv
// wired-and pin model joining the host end and the slave end
`timescale 1ns/1ps
interface rts_if;
    // host drive
    logic m_scl_o;
    logic m_scl_oe;
    logic m_sda_o;
    logic m_sda_oe;
    // slave drive
    logic s_sda_o;
    logic s_sda_oe;
    // resolved levels, high when every party releases
    logic scl;
    logic sda;

    assign scl = !(m_scl_oe && !m_scl_o);
    assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

    modport host (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
    modport dev  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// file: rts_slave.sv
// slave end of the two-wire link: link engine, register store, write feed
`timescale 1ns/1ps
`include "rts_consts.svh"
//------------------------------------------------------------
// Summary of operation
// [RL1] lines only pulled low or released
// [RL2] both lines released when bus idle
// [RL3] slave only, never makes clock or conditions
// [RL4] transmit only after read-direction address
// [RL5] pointer advances after every data byte; a write byte refused while the write feed is busy leaves it unchanged
// [RL6] host write: start, address, pointer, data, stop
// [RL7] first write byte loads pointer, rest stored; a byte arriving while the write feed is busy is refused and not stored
// [RL8] chosen read: pointer write, repeated start, read
// [RL9] read starts at last written pointer
// [RL10] host ack low asks next byte
// [RL11] host nack ends read, slave releases
// [RL12] read without pointer: start, read address
// [RL13] plain read continues after last access
// [RL14] address 0110010 strap high, 1010001 low
// [RL15] direction bit: 0 write, 1 read
// [RL16] pointer wraps from f to 0
// [RL17] one second transaction forces standby
// [RL18] pointer kept across stop conditions
//------------------------------------------------------------
module rts_slave
    import rts_pkg::*;
#(
    parameter int TMO_CYCLES = `RTS_TMO_CYCLES,
    parameter int WORD_W     = `RTS_WORD_W,
    parameter int DEPTH      = `RTS_BUF_DEPTH
) (
    // user clock and reset
    input  wire logic              clk_in,
    input  wire logic              reset_in,
    // link clock
    input  wire logic              lnk_clk_in,
    // address strap
    input  wire logic              slave_address_select_pin_in,
    // bus pins
    rts_if.dev                     bus,
    // write feed towards the user
    output logic                   wr_valid_out,
    output logic [WORD_W-1:0]      wr_word_out,
    input  wire logic              wr_ready_in,
    // status
    output logic                   timeout_out,
    output logic                   feed_full_out
);
    localparam int TW = $clog2(TMO_CYCLES + 1);

    if (TMO_CYCLES < 2 || WORD_W != `RTS_WORD_W || DEPTH != `RTS_BUF_DEPTH) begin : g_bad
        $error("rts_slave: unsupported parameter values");
    end

    //------------------------------------------------------------
    // link domain
    //------------------------------------------------------------
    logic              lrst_s1, lrst;
    logic              scl_s1, scl_s2, scl_p;
    logic              sda_s1, sda_s2, sda_p;
    logic              sel_s1, sel_s2;
    logic              ack_s1, ack_s2;
    logic              seen, next_seen;
    rts_sst_type       st, next_st, after, next_after;
    logic [3:0]        cnt, next_cnt;
    logic [7:0]        shreg, next_sh;
    logic [3:0]        ptr, next_ptr;
    logic [7:0]        regs [`RTS_NUM_REGS];
    logic [7:0]        next_regs [`RTS_NUM_REGS];
    logic              sda_oe, next_oe;
    logic              more, next_more;
    logic [TW-1:0]     tmr, next_tmr;
    logic              tmo, next_tmo;
    logic              push_tgl, next_push;
    logic [WORD_W-1:0] word, next_word;
    logic              start, stop, scl_rise, scl_fall, feed_busy;
    logic [6:0]        own;

    // pointer step, wrapping past the top location
    function automatic logic [3:0] ptr_inc(input logic [3:0] p);
        ptr_inc = p + 4'h1; // RL16
    endfunction

    // open-drain: drive only low, release otherwise
    assign bus.s_sda_o  = 1'b0; // RL1
    assign bus.s_sda_oe = sda_oe; // RL1

    // synchronisers; logic reads the second stage, and also the third (scl_p, sda_p) for edge decode
    always_ff @(posedge lnk_clk_in) begin
        lrst_s1 <= reset_in;
        lrst    <= lrst_s1;
        scl_s1  <= bus.scl;
        scl_s2  <= scl_s1;
        scl_p   <= scl_s2;
        sda_s1  <= bus.sda;
        sda_s2  <= sda_s1;
        sda_p   <= sda_s2;
        sel_s1  <= slave_address_select_pin_in;
        sel_s2  <= sel_s1;
        ack_s1  <= seen;
        ack_s2  <= ack_s1;
    end

    // bus condition and edge decode
    assign start     = scl_s2 && scl_p && sda_p && !sda_s2;
    assign stop      = scl_s2 && scl_p && !sda_p && sda_s2;
    assign scl_rise  = scl_s2 && !scl_p;
    assign scl_fall  = !scl_s2 && scl_p;
    assign feed_busy = push_tgl != ack_s2;
    assign own       = sel_s2 ? `RTS_ADDR_SEL_HI : `RTS_ADDR_SEL_LO; // RL14

    // link engine next state; reacts to host edges and to the timeout
    always_comb begin
        next_st    = st; // RL3
        next_after = after;
        next_cnt   = cnt;
        next_sh    = shreg;
        next_ptr   = ptr;
        next_regs  = regs;
        next_oe    = sda_oe;
        next_more  = more;
        next_tmo   = tmo;
        next_push  = push_tgl;
        next_word  = word;
        next_tmr   = (st == ST_IDLE) ? '0 : tmr + 1'b1;
        if (start) begin
            next_st  = ST_ADDR;
            next_cnt = '0;
            next_oe  = 1'b0;
            if (tmo) begin
                next_tmo = 1'b0; // RL17
                next_tmr = '0;
            end
        end else if (stop) begin
            next_st = ST_IDLE; // RL2
            next_oe = 1'b0; // RL18
        end else if (st != ST_IDLE && tmr >= TW'(TMO_CYCLES - 1)) begin
            next_st  = ST_IGNORE; // RL17
            next_oe  = 1'b0;
            next_tmo = 1'b1;
        end else begin
            case (st)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise && cnt != `RTS_ACK_BIT) begin
                        next_sh  = {shreg[6:0], sda_s2};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == `RTS_ACK_BIT) begin
                        next_cnt = '0;
                        next_st  = ST_ACK;
                        next_oe  = 1'b1;
                        if (st == ST_ADDR) begin
                            if (shreg[7:1] != own) begin
                                next_st = ST_IGNORE; // RL14
                                next_oe = 1'b0;
                            end else if (shreg[0] == `RTS_DIR_READ) begin
                                next_after = ST_RDATA; // RL15
                            end else begin
                                next_after = ST_PTR; // RL15
                            end
                        end else if (st == ST_PTR) begin
                            next_ptr   = shreg[3:0]; // RL7
                            next_after = ST_WDATA;
                        end else if (feed_busy) begin
                            next_st = ST_IGNORE; // feed full: refuse byte
                            next_oe = 1'b0;
                        end else begin
                            next_regs[ptr] = shreg; // RL7
                            next_word      = {ptr, shreg};
                            next_push      = !push_tgl;
                            next_ptr       = ptr_inc(ptr); // RL5
                            next_after     = ST_WDATA;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        next_oe = 1'b0;
                        next_st = after;
                        if (after == ST_RDATA) begin
                            next_sh = regs[ptr]; // RL9
                            next_oe = !regs[ptr][7]; // RL4
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (cnt == 4'h7) begin
                            next_oe  = 1'b0;
                            next_st  = ST_MACK;
                            next_ptr = ptr_inc(ptr); // RL5
                        end else begin
                            next_cnt = cnt + 4'h1;
                            next_sh  = {shreg[6:0], 1'b0};
                            next_oe  = !shreg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        next_more = !sda_s2; // RL10
                    end else if (scl_fall) begin
                        if (more) begin
                            next_sh  = regs[ptr]; // RL13
                            next_oe  = !regs[ptr][7]; // RL10
                            next_cnt = '0;
                            next_st  = ST_RDATA;
                        end else begin
                            next_st = ST_IGNORE; // RL11
                        end
                    end
                end
                default: ;
            endcase
        end
    end

    // link engine registers
    always_ff @(posedge lnk_clk_in) begin
        if (lrst) begin
            st       <= ST_IDLE;
            after    <= ST_IDLE;
            cnt      <= '0;
            shreg    <= '0;
            ptr      <= `RTS_PTR_RST;
            sda_oe   <= 1'b0;
            more     <= 1'b0;
            tmr      <= '0;
            tmo      <= 1'b0;
            push_tgl <= 1'b0;
            word     <= '0;
            for (int i = 0; i < `RTS_NUM_REGS; i++) begin
                regs[i] <= `RTS_REG_RST;
            end
        end else begin
            st       <= next_st;
            after    <= next_after;
            cnt      <= next_cnt;
            shreg    <= next_sh;
            ptr      <= next_ptr;
            sda_oe   <= next_oe;
            more     <= next_more;
            tmr      <= next_tmr;
            tmo      <= next_tmo;
            push_tgl <= next_push;
            word     <= next_word;
            regs     <= next_regs;
        end
    end

    //------------------------------------------------------------
    // user domain: toggle crossing into a two-entry buffer
    //------------------------------------------------------------
    logic              push_s1, push_s2, tmo_s1, tmo_s2;
    logic              out_v, next_out_v, sk_v, next_sk_v;
    logic [WORD_W-1:0] out_d, next_out_d, sk_d, next_sk_d;
    logic              take, pop;

    // word is stable while its toggle is unanswered
    always_ff @(posedge clk_in) begin
        push_s1 <= push_tgl;
        push_s2 <= push_s1;
        tmo_s1  <= tmo;
        tmo_s2  <= tmo_s1;
    end

    assign take = (push_s2 != seen) && !sk_v;
    assign pop  = out_v && wr_ready_in;

    // head and skid entry update
    always_comb begin
        next_seen  = seen;
        next_out_v = out_v;
        next_out_d = out_d;
        next_sk_v  = sk_v;
        next_sk_d  = sk_d;
        if (pop) begin
            next_out_v = sk_v;
            next_out_d = sk_v ? sk_d : out_d;
            next_sk_v  = 1'b0;
        end
        if (take) begin
            next_seen = push_s2;
            if (!next_out_v) begin
                next_out_v = 1'b1;
                next_out_d = word;
            end else begin
                next_sk_v = 1'b1;
                next_sk_d = word;
            end
        end
    end

    // buffer and status registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            seen          <= 1'b0;
            out_v         <= 1'b0;
            out_d         <= '0;
            sk_v          <= 1'b0;
            sk_d          <= '0;
            timeout_out   <= 1'b0;
            feed_full_out <= 1'b0;
        end else begin
            seen          <= next_seen;
            out_v         <= next_out_v;
            out_d         <= next_out_d;
            sk_v          <= next_sk_v;
            sk_d          <= next_sk_d;
            timeout_out   <= tmo_s2;
            feed_full_out <= next_sk_v;
        end
    end

    assign wr_valid_out = out_v;
    assign wr_word_out  = out_d;
endmodule

// file: rts_master.sv
// host end of the two-wire link: byte-level command sequencer
`timescale 1ns/1ps
`include "rts_consts.svh"
module rts_master
    import rts_pkg::*;
#(
    parameter int QTR_CYCLES = `RTS_QTR_CYCLES
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // bus pins
    rts_if.host              bus,
    // command
    input  wire logic        cmd_valid_in,
    output logic             cmd_ready_out,
    input  wire rts_cmd_type cmd_kind_in,
    input  wire logic [7:0]  cmd_data_in,
    input  wire logic        cmd_nack_in,
    // answer
    output logic             rsp_valid_out,
    output logic [7:0]       rsp_data_out,
    output logic             rsp_nack_out
);
    localparam int QW = $clog2(QTR_CYCLES + 1);

    if (QTR_CYCLES < 3) begin : g_bad
        $error("rts_master: QTR_CYCLES below 3");
    end

    rts_mst_type   st, next_st;
    rts_cmd_type   kind, next_kind;
    logic [QW-1:0] qc, next_qc;
    logic [1:0]    q, next_q;
    logic [3:0]    bit_idx, next_bit;
    logic [7:0]    sh, next_sh;
    logic          nack, next_nack, rx_nack, next_rx_nack;
    logic          scl_oe, next_scl_oe, sda_oe, next_sda_oe;
    logic          rdy, next_rdy, rsp_v, next_rsp_v;
    logic          sda_s1, sda_s2;
    logic [1:0]    ab;

    // data-line pull in quarter 1 and quarter 3 of the current slot
    function automatic logic [1:0] drive_ab(input rts_cmd_type k, input logic [3:0] b,
                                            input logic [7:0] d, input logic n);
        logic lo;
        lo = 1'b0;
        case (k)
            RTS_CMD_START: drive_ab = 2'b01; // RL8
            RTS_CMD_STOP:  drive_ab = 2'b10; // RL2
            RTS_CMD_WRITE: begin
                lo       = (b != `RTS_ACK_BIT) && !d[7]; // RL6
                drive_ab = {lo, lo};
            end
            default: begin
                lo       = (b == `RTS_ACK_BIT) && !n; // RL10
                drive_ab = {lo, lo}; // RL11
            end
        endcase
    endfunction

    // open-drain pins: pull low or release
    assign bus.m_scl_o  = 1'b0; // RL1
    assign bus.m_sda_o  = 1'b0; // RL1
    assign bus.m_scl_oe = scl_oe;
    assign bus.m_sda_oe = sda_oe;

    // data-line synchroniser
    always_ff @(posedge clk_in) begin
        sda_s1 <= bus.sda;
        sda_s2 <= sda_s1;
    end

    // quarter sequencer: clock low, data set, clock high, sample
    always_comb begin
        next_st      = st;
        next_kind    = kind;
        next_qc      = qc;
        next_q       = q;
        next_bit     = bit_idx;
        next_sh      = sh;
        next_nack    = nack;
        next_rx_nack = rx_nack;
        next_scl_oe  = scl_oe;
        next_sda_oe  = sda_oe;
        next_rdy     = rdy;
        next_rsp_v   = 1'b0;
        ab           = drive_ab(kind, bit_idx, sh, nack);
        case (st)
            M_IDLE: begin
                if (cmd_valid_in) begin
                    next_st     = M_RUN;
                    next_kind   = cmd_kind_in; // RL12
                    next_sh     = cmd_data_in; // RL15
                    next_nack   = cmd_nack_in;
                    next_bit    = '0;
                    next_q      = '0;
                    next_qc     = '0;
                    next_scl_oe = 1'b1;
                    next_rdy    = 1'b0;
                end
            end
            M_RUN: begin
                next_qc = qc + 1'b1;
                if (qc == QW'(QTR_CYCLES - 1)) begin
                    next_qc = '0;
                    next_q  = q + 2'h1;
                    case (q)
                        2'h0: next_sda_oe = ab[1];
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: next_sda_oe = ab[0];
                        default: begin
                            if (bit_idx == `RTS_ACK_BIT) begin
                                next_rx_nack = sda_s2;
                            end else begin
                                next_sh = {sh[6:0], sda_s2};
                            end
                            if (kind == RTS_CMD_START || kind == RTS_CMD_STOP ||
                                bit_idx == `RTS_ACK_BIT) begin
                                next_st    = M_IDLE;
                                next_rdy   = 1'b1;
                                next_rsp_v = 1'b1;
                            end else begin
                                next_bit    = bit_idx + 4'h1;
                                next_scl_oe = 1'b1;
                            end
                        end
                    endcase
                end
            end
            default: next_st = M_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            st      <= M_IDLE;
            kind    <= RTS_CMD_START;
            qc      <= '0;
            q       <= '0;
            bit_idx <= '0;
            sh      <= '0;
            nack    <= 1'b0;
            rx_nack <= 1'b0;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            rdy     <= 1'b1;
            rsp_v   <= 1'b0;
        end else begin
            st      <= next_st;
            kind    <= next_kind;
            qc      <= next_qc;
            q       <= next_q;
            bit_idx <= next_bit;
            sh      <= next_sh;
            nack    <= next_nack;
            rx_nack <= next_rx_nack;
            scl_oe  <= next_scl_oe;
            sda_oe  <= next_sda_oe;
            rdy     <= next_rdy;
            rsp_v   <= next_rsp_v;
        end
    end

    assign cmd_ready_out = rdy;
    assign rsp_valid_out = rsp_v;
    assign rsp_data_out  = sh;
    assign rsp_nack_out  = rx_nack;
endmodule

// file: rts_monitor.sv
// checker of the two-wire link pins
`timescale 1ns/1ps
module rts_monitor (
    // clocks and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    input  wire logic lnk_clk_in,
    // drives and resolved levels
    input  wire logic m_scl_o,
    input  wire logic m_scl_oe,
    input  wire logic m_sda_o,
    input  wire logic m_sda_oe,
    input  wire logic s_sda_o,
    input  wire logic s_sda_oe,
    input  wire logic scl,
    input  wire logic sda
);
    logic scl_q;
    logic sda_q;
    logic busy;
    logic stop;

    // stop seen on the resolved lines
    assign stop = scl && scl_q && !sda_q && sda;

    // bus busy from start to stop
    always_ff @(posedge clk_in) begin
        scl_q <= scl;
        sda_q <= sda;
        if (reset_in)
            busy <= 1'b0;
        else if (scl && scl_q && sda_q && !sda)
            busy <= 1'b1;
        else if (stop)
            busy <= 1'b0;
    end

    sequence s_low;
        m_scl_oe [*8];
    endsequence

    property p_open_drain;
        @(posedge clk_in) disable iff (reset_in) !m_scl_o && !m_sda_o && !s_sda_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    property p_idle_quiet;
        @(posedge clk_in) disable iff (reset_in) !busy |-> !s_sda_oe;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("slave drives idle bus");
    property p_dev_quiet_high;
        @(posedge lnk_clk_in) disable iff (reset_in) scl && $past(scl) |-> $stable(s_sda_oe);
    endproperty
    a_dev_quiet_high: assert property (p_dev_quiet_high) else $error("slave edge in high");
    property p_dev_drive_low;
        @(posedge lnk_clk_in) disable iff (reset_in) $rose(s_sda_oe) |-> !scl;
    endproperty
    a_dev_drive_low: assert property (p_dev_drive_low) else $error("slave drive in high");
    property p_scl_low;
        @(posedge clk_in) disable iff (reset_in) $rose(m_scl_oe) |-> s_low ##[1:40] !m_scl_oe;
    endproperty
    a_scl_low: assert property (p_scl_low) else $error("clock low phase wrong");
    property p_scl_high;
        @(posedge clk_in) disable iff (reset_in) $fell(m_scl_oe) |-> !m_scl_oe [*8];
    endproperty
    a_scl_high: assert property (p_scl_high) else $error("clock high phase short");
    property p_stop_quiet;
        @(posedge clk_in) disable iff (reset_in) stop |=> !s_sda_oe [*8];
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("slave drives after stop");
    property p_drive_len;
        @(posedge lnk_clk_in) disable iff (reset_in) $rose(s_sda_oe) |-> ##[1:300] !s_sda_oe;
    endproperty
    a_drive_len: assert property (p_drive_len) else $error("slave holds data line");
endmodule

// file: rtc_i2c_slave_register_access_tb.sv
// self-checking bench of the two-wire register link
`timescale 1ns/1ps
module rtc_i2c_slave_register_access_tb;
    import rts_pkg::*;
    logic        clk_in = 1'b0;
    logic        lnk_clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        sel = 1'b1;
    logic        cmd_valid = 1'b0;
    rts_cmd_type kind = RTS_CMD_START;
    logic [7:0]  cdata = 8'h00;
    logic        cnack = 1'b0;
    logic        wr_ready = 1'b1;
    logic        cmd_ready, rsp_valid, rsp_nack, wr_valid, tmo, full;
    logic [7:0]  rsp_data;
    logic [11:0] wr_word;
    logic [11:0] q[$];
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;

    rts_if bus();
    rts_master #(.QTR_CYCLES(8)) i_rts_master (.clk_in(clk_in), .reset_in(reset_in),
        .bus(bus), .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_kind_in(kind),
        .cmd_data_in(cdata), .cmd_nack_in(cnack), .rsp_valid_out(rsp_valid),
        .rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack));
    rts_slave #(.TMO_CYCLES(2000)) i_rts_slave (.clk_in(clk_in), .reset_in(reset_in),
        .lnk_clk_in(lnk_clk_in), .slave_address_select_pin_in(sel), .bus(bus),
        .wr_valid_out(wr_valid), .wr_word_out(wr_word), .wr_ready_in(wr_ready),
        .timeout_out(tmo), .feed_full_out(full));
    rts_monitor i_rts_monitor (.clk_in(clk_in), .reset_in(reset_in), .lnk_clk_in(lnk_clk_in),
        .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe), .m_sda_o(bus.m_sda_o),
        .m_sda_oe(bus.m_sda_oe), .s_sda_o(bus.s_sda_o), .s_sda_oe(bus.s_sda_oe),
        .scl(bus.scl), .sda(bus.sda));

    // host clock and a link clock of unrelated phase
    always #20 clk_in = ~clk_in;
    initial begin
        #13;
        forever #40 lnk_clk_in = ~lnk_clk_in;
    end

    // collect accepted feed words, cut a hang short
    always @(posedge clk_in) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            q.push_back(wr_word);
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one host command, back from its answer pulse
    task automatic cmd(input rts_cmd_type k, input logic [7:0] d, input logic n);
        int i;
        cmd_valid <= 1'b1;
        kind <= k;
        cdata <= d;
        cnack <= n;
        @(posedge clk_in);
        while (cmd_ready !== 1'b1) @(posedge clk_in);
        cmd_valid <= 1'b0;
        for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(posedge clk_in);
    endtask

    task automatic start_c;
        cmd(RTS_CMD_START, 8'h00, 1'b0);
    endtask
    task automatic stop_c;
        cmd(RTS_CMD_STOP, 8'h00, 1'b0);
    endtask
    task automatic wb(input logic [7:0] d, input logic nk);
        cmd(RTS_CMD_WRITE, d, 1'b0);
        chk(12'(rsp_nack), 12'(nk));
    endtask
    task automatic rb(input logic n, input logic [7:0] exp);
        cmd(RTS_CMD_READ, 8'h00, n);
        chk(12'(rsp_data), 12'(exp));
    endtask

    //--------------------------------------------------
    // scenarios
    //--------------------------------------------------
    task automatic t_write;
        start_c();
        wb({7'h32, 1'b0}, 1'b0);
        wb(8'h0e, 1'b0);
        wb(8'h11, 1'b0);
        wb(8'h22, 1'b0);
        wb(8'h33, 1'b0);
        stop_c();
        chk(12'(q.size()), 12'h003);
        chk(q.pop_front(), 12'he11);
        chk(q.pop_front(), 12'hf22);
        chk(q.pop_front(), 12'h033);
        $display("write test done");
    endtask
    task automatic t_read;
        start_c();
        wb({7'h32, 1'b0}, 1'b0);
        wb(8'h0e, 1'b0);
        start_c();
        wb({7'h32, 1'b1}, 1'b0);
        rb(1'b0, 8'h11);
        rb(1'b1, 8'h22);
        stop_c();
        $display("chosen read test done");
    endtask
    task automatic t_plain;
        start_c();
        wb({7'h32, 1'b1}, 1'b0);
        rb(1'b0, 8'h33);
        rb(1'b1, 8'h00);
        stop_c();
        $display("plain read test done");
    endtask
    task automatic t_strap;
        int i;
        sel <= 1'b0;
        start_c();
        wb({7'h32, 1'b0}, 1'b1);
        stop_c();
        start_c();
        wb({7'h51, 1'b0}, 1'b0);
        wb(8'h05, 1'b0);
        wr_ready <= 1'b0;
        wb(8'h77, 1'b0);
        wb(8'h88, 1'b0);
        stop_c();
        chk(12'(full), 12'h001);
        wr_ready <= 1'b1;
        for (i = 0; i < 20 && q.size() < 2; i++) @(posedge clk_in);
        chk(q.pop_front(), 12'h577);
        chk(q.pop_front(), 12'h688);
        $display("strap and stall test done");
    endtask
    task automatic t_tmo;
        start_c();
        repeat (4200) @(posedge clk_in);
        chk(12'(tmo), 12'h001);
        wb({7'h51, 1'b0}, 1'b1);
        rb(1'b1, 8'hff);
        stop_c();
        start_c();
        wb({7'h51, 1'b0}, 1'b0);
        chk(12'(tmo), 12'h000);
        stop_c();
        $display("timeout test done");
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clk_in);
        reset_in <= 1'b0;
        repeat (8) @(posedge clk_in);
        t_write();
        t_read();
        t_plain();
        t_strap();
        t_tmo();
        close_out();
    end
endmodule
